// File: design/host_port_defines.svh
// Constants of the host parallel register port.
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define DATA_W 8
`define ADDR_W 6
`define REG_COUNT 64
`define SYNC_STAGES 3
`define RESET_DATA 8'h00
`endif

// File: design/host_port_pkg.sv
// Types of the host parallel register port.
`include "host_port_defines.svh"
package host_port_pkg;
	typedef logic [`DATA_W-1:0] data_t;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef enum logic [1:0] {st_idle, st_read, st_write} port_state_t;
endpackage : host_port_pkg

// File: design/reg_store.sv
// Register store with one write port and a registered read port.
`timescale 1ns/1ns
`include "host_port_defines.svh"
module reg_store (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Write port
	input wire logic wr_en,
	input wire host_port_pkg::addr_t wr_addr,
	input wire host_port_pkg::data_t wr_data,
	// Read port
	input wire logic rd_en,
	input wire host_port_pkg::addr_t rd_addr,
	output host_port_pkg::data_t rd_data_ff
);
	host_port_pkg::data_t mem_ff [`REG_COUNT];
	host_port_pkg::data_t nxt_rd_data;

	always_comb begin
		nxt_rd_data = rd_data_ff;
		if (rd_en) begin
			nxt_rd_data = mem_ff[rd_addr];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= `RESET_DATA;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end
endmodule : reg_store

// File: design/uart_host_bus_port.sv
// Host parallel register port: pins sampled on ref_clk, register decode and data bus drive.
// Operation
// - The data bus is eight bits wide, two-way, three-state and active high, bit 0 the least significant.
// - While chip select is low the read and write strobes set the direction of the bus.
// - While chip select is high the bus floats and all bus activity is ignored.
// - Transfers happen only with chip select low and under control of the strobes and address.
// - A write strobe low with chip select low copies the bus into the addressed register.
// - Written data are taken at the rising trailing edge of the write strobe, so the host holds them to it.
// - A read strobe low with chip select low drives the addressed register onto the bus.
// - The falling edge of the read strobe starts a read and carries any read side effect.
// - The six-bit active-high address selects one register for each access.
`timescale 1ns/1ns
`include "host_port_defines.svh"
module uart_host_bus_port (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Host pins
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire host_port_pkg::addr_t register_address,
	input wire host_port_pkg::data_t host_data_bus_in,
	output host_port_pkg::data_t host_data_bus_out,
	output logic host_data_bus_oe,
	// Internal side
	output host_port_pkg::addr_t reg_select_ff,
	output logic reg_write_ff,
	output host_port_pkg::data_t reg_write_data_ff,
	output logic reg_read_start_ff
);
	logic [1:0] rst_sync_ff;
	logic rst_n;
	localparam int PW = 3 + `ADDR_W + `DATA_W;
	logic [PW-1:0] pin_s1_ff;
	logic [PW-1:0] pin_s2_ff;
	logic [PW-1:0] pin_s3_ff;
	logic [PW-1:0] pin_q_ff;
	logic [PW-1:0] nxt_pin_q;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	host_port_pkg::addr_t adr;
	host_port_pkg::data_t din;
	host_port_pkg::port_state_t state_ff;
	host_port_pkg::port_state_t nxt_state;
	host_port_pkg::addr_t nxt_sel;
	host_port_pkg::data_t nxt_wdata;
	logic nxt_write;
	logic nxt_rstart;
	logic drive_ff;
	logic nxt_drive;
	host_port_pkg::data_t rd_data;

	function automatic logic read_request(input logic cs_in_n, input logic rd_in_n, input logic wr_in_n);
		return !cs_in_n && !rd_in_n && wr_in_n;
	endfunction : read_request

	function automatic logic write_request(input logic cs_in_n, input logic rd_in_n, input logic wr_in_n);
		return !cs_in_n && !wr_in_n && rd_in_n;
	endfunction : write_request

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// Each bit passes three flops and counts once the last two agree.
	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++) begin : g_filt
			always_comb begin
				nxt_pin_q[gi] = (pin_s2_ff[gi] == pin_s3_ff[gi]) ? pin_s3_ff[gi] : pin_q_ff[gi];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= {3'h7, {(PW-3){1'b0}}};
			pin_s2_ff <= {3'h7, {(PW-3){1'b0}}};
			pin_s3_ff <= {3'h7, {(PW-3){1'b0}}};
			pin_q_ff <= {3'h7, {(PW-3){1'b0}}};
		end else begin
			pin_s1_ff <= {chip_select_n, read_strobe_n, write_strobe_n, register_address, host_data_bus_in};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			pin_q_ff <= nxt_pin_q;
		end
	end

	assign {cs_n, rd_n, wr_n, adr, din} = pin_q_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_sel = reg_select_ff;
		nxt_wdata = reg_write_data_ff;
		nxt_write = 1'b0;
		nxt_rstart = 1'b0;
		nxt_drive = 1'b0;
		unique case (state_ff)
			host_port_pkg::st_idle: begin
				if (read_request(cs_n, rd_n, wr_n)) begin
					nxt_state = host_port_pkg::st_read;
					nxt_sel = adr;
					nxt_rstart = 1'b1;
				end else if (write_request(cs_n, rd_n, wr_n)) begin
					nxt_state = host_port_pkg::st_write;
				end
			end
			host_port_pkg::st_read: begin
				nxt_drive = !cs_n && !rd_n;
				if (cs_n || rd_n) begin
					nxt_state = host_port_pkg::st_idle;
				end
			end
			host_port_pkg::st_write: begin
				if (cs_n) begin
					nxt_state = host_port_pkg::st_idle;
				end else if (wr_n) begin
					nxt_state = host_port_pkg::st_idle;
					nxt_write = 1'b1;
				end else begin
					nxt_sel = adr;
					nxt_wdata = din;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= host_port_pkg::st_idle;
			reg_select_ff <= '0;
			reg_write_data_ff <= `RESET_DATA;
			reg_write_ff <= 1'b0;
			reg_read_start_ff <= 1'b0;
			drive_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			reg_select_ff <= nxt_sel;
			reg_write_data_ff <= nxt_wdata;
			reg_write_ff <= nxt_write;
			reg_read_start_ff <= nxt_rstart;
			drive_ff <= nxt_drive;
		end
	end

	reg_store u_store (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(reg_write_ff),
		.wr_addr(reg_select_ff),
		.wr_data(reg_write_data_ff),
		.rd_en(reg_read_start_ff),
		.rd_addr(reg_select_ff),
		.rd_data_ff(rd_data)
	);

	// The bus is driven only while the qualified read is still active.
	assign host_data_bus_oe = drive_ff && !cs_n && !rd_n;
	assign host_data_bus_out = rd_data;

	sequence s_read_begin;
		state_ff == host_port_pkg::st_idle && read_request(cs_n, rd_n, wr_n);
	endsequence
	sequence s_write_end;
		state_ff == host_port_pkg::st_write && !cs_n && wr_n;
	endsequence
	sequence s_read_held;
		state_ff == host_port_pkg::st_read && !cs_n && !rd_n;
	endsequence
	sequence s_write_hold;
		state_ff == host_port_pkg::st_write && !cs_n && !wr_n;
	endsequence

	chk_float_when_deselected: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cs_n |-> !host_data_bus_oe) else $error("Bus driven while deselected.");
	chk_read_start_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_begin |=> reg_read_start_ff ##1 !reg_read_start_ff) else $error("Read start not one pulse.");
	chk_read_drives_bus: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_begin ##1 (!cs_n && !rd_n)[*2] |-> host_data_bus_oe) else $error("Read did not drive bus.");
	chk_write_on_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_write_end |=> reg_write_ff) else $error("Write not taken at strobe rise.");
	chk_write_needs_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_write_ff |-> $past(state_ff) == host_port_pkg::st_write) else $error("Write without strobe.");
	chk_write_data_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_write_end |=> reg_write_data_ff == $past(reg_write_data_ff)) else $error("Write data changed.");
	chk_read_addr_taken: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_begin |=> reg_select_ff == $past(adr)) else $error("Read address not captured.");
	chk_no_drive_on_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == host_port_pkg::st_write |-> !host_data_bus_oe) else $error("Bus driven during write.");
	chk_deselect_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cs_n && state_ff == host_port_pkg::st_write) |=> !reg_write_ff) else $error("Write without select.");
	chk_read_data_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(host_data_bus_oe && $past(host_data_bus_oe)) |-> $stable(host_data_bus_out)) else $error("Read data moved.");

	chk_read_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_ff == host_port_pkg::st_read && (cs_n || rd_n)) |=> (state_ff == host_port_pkg::st_idle && !drive_ff))
		else $error("Read not ended on release.");
	chk_idle_no_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == host_port_pkg::st_idle |-> !drive_ff) else $error("Drive left on in idle.");
	chk_both_strobes_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_ff == host_port_pkg::st_idle && !cs_n && !rd_n && !wr_n) |=>
		(state_ff == host_port_pkg::st_idle && !reg_read_start_ff)) else $error("Strobe clash not refused.");
	chk_deselect_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_ff == host_port_pkg::st_idle && cs_n) |=>
		(state_ff == host_port_pkg::st_idle && !reg_read_start_ff && !reg_write_ff))
		else $error("Activity while deselected.");
	chk_write_single_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_write_ff |=> !reg_write_ff) else $error("Write pulse too long.");
	chk_read_select_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_held |=> $stable(reg_select_ff)) else $error("Select moved during read.");
	chk_write_captures_bus: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_write_hold |=> (reg_write_data_ff == $past(din) && reg_select_ff == $past(adr)))
		else $error("Write data not tracked.");
	chk_read_needs_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_read_start_ff |-> (!$past(cs_n) && $past(state_ff) == host_port_pkg::st_idle)) else $error("Read without select.");
	chk_write_needs_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reg_write_ff |-> !$past(cs_n)) else $error("Write commit without select.");
endmodule : uart_host_bus_port

// File: tb/host_model.sv
// Host processor model that drives the port pins.
`timescale 1ns/1ns
module host_model (
	// Clock and bus as seen by the host
	input wire logic ref_clk,
	input wire host_port_pkg::data_t bus,
	// Host pins
	output logic chip_select_n = 1'b1,
	output logic read_strobe_n = 1'b1,
	output logic write_strobe_n = 1'b1,
	output host_port_pkg::addr_t register_address = 6'h00,
	output host_port_pkg::data_t host_data = 8'h00
);
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step
	// One access; a released data line shows the inverse of the last byte.
	task automatic access(input logic cs_n, input logic wr, input host_port_pkg::addr_t a,
		input host_port_pkg::data_t d, output host_port_pkg::data_t q);
		step(1);
		chip_select_n = cs_n;
		register_address = a;
		host_data = d;
		write_strobe_n = !wr;
		read_strobe_n = wr;
		step(12);
		q = bus;
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		step(8);
		chip_select_n = 1'b1;
		host_data = ~d;
		step(4);
	endtask : access
	// Both strobes low together, which the port must refuse.
	task automatic clash(input host_port_pkg::addr_t a, input host_port_pkg::data_t d);
		step(1);
		chip_select_n = 1'b0;
		register_address = a;
		host_data = d;
		write_strobe_n = 1'b0;
		read_strobe_n = 1'b0;
		step(12);
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		step(8);
		chip_select_n = 1'b1;
		step(4);
	endtask : clash
endmodule : host_model

// File: tb/tb_top.sv
// Self-checking bench of the host parallel register port.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t mismatch", $time); end end
module tb_top;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	int bad_count = 0;
	int n_tests = 0;
	int n_wr = 0;
	int n_rd = 0;
	int n_oe = 0;
	logic cs_n, rd_n, wr_n, oe, wr_p, rd_p;
	host_port_pkg::addr_t addr, sel, wr_sel, rd_sel;
	host_port_pkg::data_t host_data, bus_out, bus_in, wdat, wr_data, q;
	assign bus_in = oe ? bus_out : host_data;
	uart_host_bus_port u_uart_host_bus_port (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.chip_select_n(cs_n),
		.read_strobe_n(rd_n),
		.write_strobe_n(wr_n),
		.register_address(addr),
		.host_data_bus_in(bus_in),
		.host_data_bus_out(bus_out),
		.host_data_bus_oe(oe),
		.reg_select_ff(sel),
		.reg_write_ff(wr_p),
		.reg_write_data_ff(wdat),
		.reg_read_start_ff(rd_p)
	);
	host_model u_host_model (
		.ref_clk(ref_clk),
		.bus(bus_in),
		.chip_select_n(cs_n),
		.read_strobe_n(rd_n),
		.write_strobe_n(wr_n),
		.register_address(addr),
		.host_data(host_data)
	);
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (oe === 1'b1) n_oe++;
		if (wr_p === 1'b1) begin
			n_wr++;
			wr_sel = sel;
			wr_data = wdat;
		end
		if (rd_p === 1'b1) begin
			n_rd++;
			rd_sel = sel;
		end
	end
	task automatic t_write_read;
		host_port_pkg::addr_t a[3] = '{6'h00, 6'h3f, 6'h15};
		host_port_pkg::data_t d[3] = '{8'h01, 8'h80, 8'ha5};
		n_oe = 0;
		for (int i = 0; i < 3; i++) begin
			u_host_model.access(1'b0, 1'b1, a[i], d[i], q);
			`CHK(n_wr, i + 1)
			`CHK({wr_sel, wr_data}, {a[i], d[i]})
		end
		`CHK(n_oe, 0)
		for (int i = 0; i < 3; i++) begin
			u_host_model.access(1'b0, 1'b0, a[i], ~d[i], q);
			`CHK(q, d[i])
			`CHK(rd_sel, a[i])
			`CHK(oe, 1'b0)
		end
		`CHK(n_rd, 3)
		$display("t_write_read done");
	endtask : t_write_read
	task automatic t_cs_high;
		n_oe = 0;
		u_host_model.access(1'b1, 1'b1, 6'h15, 8'h5a, q);
		`CHK(n_wr, 3)
		u_host_model.access(1'b1, 1'b0, 6'h15, 8'h3c, q);
		u_host_model.clash(6'h15, 8'h5a);
		`CHK(n_wr, 3)
		`CHK(n_oe, 0)
		`CHK(n_rd, 3)
		u_host_model.access(1'b0, 1'b0, 6'h15, 8'h5a, q);
		`CHK(q, 8'ha5)
		$display("t_cs_high done");
	endtask : t_cs_high
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	initial begin
		repeat (16) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		u_host_model.step(4);
		t_write_read();
		t_cs_high();
		results();
	end
	initial begin
		#20000;
		bad_count++;
		results();
	end
endmodule : tb_top
